// ---- rtl/pmrc_top.v ----
// pmrc_top.v: pad mode and rail configuration bank, port 2 pins 6..9 plus rail selects
// assumes: plain register port, one-cycle strobes, read data valid the cycle after
// Overview of operation
// - bits 9:8 pick direction and pull
// - direction/pull resets to input pull-down
// - analog mode ignores direction/pull field
// - bits 4:0 function select, reset zero
// - rail bit one is 1 V, zero 3 V
// - bits 7:0 rail for port 0 pins
// - bits 13:8 port 1 pins, 15:14 reserved
// - bits 9:0 port 2 pins, rest reserved
`timescale 1ns/1ps
`include "pmrc_consts.vh"
`default_nettype none

module pmrc_top
(
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire [31:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [15:0] reg_rdata_o,
  input  wire [3:0]  analog_mode_i,
  output wire [7:0]  direction_pull_select_o,
  output wire [19:0] pin_function_select_o,
  output wire [3:0]  pad_out_en_o,
  output wire [3:0]  pad_pull_up_o,
  output wire [3:0]  pad_pull_down_o,
  output wire [7:0]  port_zero_rail_bits_o,
  output wire [5:0]  port_one_rail_bits_o,
  output wire [9:0]  port_two_rail_bits_o
);

  // ==================================================================
  // address decode
  function hit;
    input [31:0] addr;
    input [31:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  wire [3:0] pin_wr;
  wire       p01_wr;
  wire       p2_wr;
  wire [15:0] pin_rd0;
  wire [15:0] pin_rd1;
  wire [15:0] pin_rd2;
  wire [15:0] pin_rd3;
  wire [13:0] p01_bits;
  wire [9:0]  p2_bits;
  reg  [15:0] rdata_d;
  reg  [15:0] rdata_q;

  assign pin_wr[0] = reg_wr_i && hit(reg_addr_i, `PMRC_PORT2_PIN6_CFG);
  assign pin_wr[1] = reg_wr_i && hit(reg_addr_i, `PMRC_PORT2_PIN7_CFG);
  assign pin_wr[2] = reg_wr_i && hit(reg_addr_i, `PMRC_PORT2_PIN8_CFG);
  assign pin_wr[3] = reg_wr_i && hit(reg_addr_i, `PMRC_PORT2_PIN9_CFG);
  assign p01_wr    = reg_wr_i && hit(reg_addr_i, `PMRC_P01_RAIL_SEL);
  assign p2_wr     = reg_wr_i && hit(reg_addr_i, `PMRC_P2_RAIL_SEL);

  // ==================================================================
  // pin mode registers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pin
      wire [15:0] rd_v;
      pmrc_pin_cfg u_pin
      (
        .sys_clk_i               (sys_clk_i),
        .reset_n_i               (reset_n_i),
        .wr_en_i                 (pin_wr[g]),
        .wr_data_i               (reg_wdata_i),
        .analog_mode_i           (analog_mode_i[g]),
        .rd_value_o              (rd_v),
        .direction_pull_select_o (direction_pull_select_o[2*g+1:2*g]),
        .pin_function_select_o   (pin_function_select_o[5*g+4:5*g]),
        .pad_out_en_o            (pad_out_en_o[g]),
        .pad_pull_up_o           (pad_pull_up_o[g]),
        .pad_pull_down_o         (pad_pull_down_o[g])
      );
    end
  endgenerate

  assign pin_rd0 = g_pin[0].rd_v;
  assign pin_rd1 = g_pin[1].rd_v;
  assign pin_rd2 = g_pin[2].rd_v;
  assign pin_rd3 = g_pin[3].rd_v;

  // ==================================================================
  // rail select registers; reserved high bits never stored
  pmrc_rail_sel #(.WIDTH(14)) u_p01
  (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .wr_en_i     (p01_wr),
    .wr_bits_i   (reg_wdata_i[`PMRC_P1_RAIL_HI:`PMRC_P0_RAIL_LO]),
    .rail_bits_o (p01_bits)
  );

  pmrc_rail_sel #(.WIDTH(10)) u_p2
  (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .wr_en_i     (p2_wr),
    .wr_bits_i   (reg_wdata_i[`PMRC_P2_RAIL_HI:`PMRC_P2_RAIL_LO]),
    .rail_bits_o (p2_bits)
  );

  assign port_zero_rail_bits_o = p01_bits[`PMRC_P0_RAIL_HI:`PMRC_P0_RAIL_LO];
  assign port_one_rail_bits_o  = p01_bits[`PMRC_P1_RAIL_HI:`PMRC_P1_RAIL_LO];
  assign port_two_rail_bits_o  = p2_bits;

  // ==================================================================
  // read path; unmapped addresses read zero
  always @*
  begin
    rdata_d = 16'h0000;
    case (reg_addr_i)
      `PMRC_PORT2_PIN6_CFG: rdata_d = pin_rd0;
      `PMRC_PORT2_PIN7_CFG: rdata_d = pin_rd1;
      `PMRC_PORT2_PIN8_CFG: rdata_d = pin_rd2;
      `PMRC_PORT2_PIN9_CFG: rdata_d = pin_rd3;
      `PMRC_P01_RAIL_SEL:   rdata_d = {2'h0, p01_bits};
      `PMRC_P2_RAIL_SEL:    rdata_d = {6'h00, p2_bits};
      default:              rdata_d = 16'h0000;
    endcase
  end

  // held between reads; only the cycle after a read is meaningful
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      rdata_q <= 16'h0000;
    else if (reg_rd_i)
      rdata_q <= rdata_d;
  end

  assign reg_rdata_o = rdata_q;

endmodule

`default_nettype wire

// ---- rtl/pmrc_consts.vh ----
// pmrc_consts.vh: offsets, field positions and reset values of the pad mode and rail bank
// assumes: included by bare name from the design files under rtl/
`ifndef PMRC_CONSTS_VH
`define PMRC_CONSTS_VH

// ==================================================================
// register offsets (halfword addresses)
`define PMRC_ADDR_W          32
`define PMRC_DATA_W          16
`define PMRC_PORT2_PIN6_CFG  32'h5000_3052
`define PMRC_PORT2_PIN7_CFG  32'h5000_3054
`define PMRC_PORT2_PIN8_CFG  32'h5000_3056
`define PMRC_PORT2_PIN9_CFG  32'h5000_3058
`define PMRC_P01_RAIL_SEL    32'h5000_3070
`define PMRC_P2_RAIL_SEL     32'h5000_3072

// ==================================================================
// pin mode fields
`define PMRC_DIRPULL_HI      9
`define PMRC_DIRPULL_LO      8
`define PMRC_FUNC_HI         4
`define PMRC_FUNC_LO         0
`define PMRC_DIRPULL_RST     2'h2
`define PMRC_FUNC_RST        5'h00
`define PMRC_DP_IN_NONE      2'h0
`define PMRC_DP_IN_UP        2'h1
`define PMRC_DP_IN_DOWN      2'h2
`define PMRC_DP_OUT          2'h3

// ==================================================================
// rail select fields
`define PMRC_P0_RAIL_HI      7
`define PMRC_P0_RAIL_LO      0
`define PMRC_P1_RAIL_HI      13
`define PMRC_P1_RAIL_LO      8
`define PMRC_P2_RAIL_HI      9
`define PMRC_P2_RAIL_LO      0
`define PMRC_P01_RAIL_RST    14'h0000
`define PMRC_P2_RAIL_RST     10'h000

`endif

// ---- rtl/pmrc_pin_cfg.v ----
// pmrc_pin_cfg.v: one pin mode register with pad decode
// assumes: write strobe already qualified by address decode
`timescale 1ns/1ps
`include "pmrc_consts.vh"
`default_nettype none

module pmrc_pin_cfg
(
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire        wr_en_i,
  input  wire [15:0] wr_data_i,
  input  wire        analog_mode_i,
  output wire [15:0] rd_value_o,
  output wire [1:0]  direction_pull_select_o,
  output wire [4:0]  pin_function_select_o,
  output wire        pad_out_en_o,
  output wire        pad_pull_up_o,
  output wire        pad_pull_down_o
);

  reg [1:0] dirpull_q;
  reg [4:0] func_q;

  // ==================================================================
  // storage
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      dirpull_q <= `PMRC_DIRPULL_RST;
      func_q    <= `PMRC_FUNC_RST;
    end
    else if (wr_en_i)
    begin
      dirpull_q <= wr_data_i[`PMRC_DIRPULL_HI:`PMRC_DIRPULL_LO];
      func_q    <= wr_data_i[`PMRC_FUNC_HI:`PMRC_FUNC_LO];
    end
  end

  // reserved bits 15:10 and 7:5 read zero
  assign rd_value_o = {6'h00, dirpull_q, 3'h0, func_q};

  assign direction_pull_select_o = dirpull_q;
  assign pin_function_select_o   = func_q;

  // ==================================================================
  // pad decode; analog mode masks the field from all three pad outputs, direction_pull_select_o still shows it
  assign pad_out_en_o    = !analog_mode_i && (dirpull_q == `PMRC_DP_OUT);
  assign pad_pull_up_o   = !analog_mode_i && (dirpull_q == `PMRC_DP_IN_UP);
  assign pad_pull_down_o = !analog_mode_i && (dirpull_q == `PMRC_DP_IN_DOWN);

endmodule

`default_nettype wire

// ---- rtl/pmrc_rail_sel.v ----
// pmrc_rail_sel.v: one rail select register, bit set picks the 1 V rail
// assumes: write strobe already qualified by address decode
`timescale 1ns/1ps
`include "pmrc_consts.vh"
`default_nettype none

module pmrc_rail_sel
#(
  parameter WIDTH = 10
)
(
  input  wire             sys_clk_i,
  input  wire             reset_n_i,
  input  wire             wr_en_i,
  input  wire [WIDTH-1:0] wr_bits_i,
  output wire [WIDTH-1:0] rail_bits_o
);

  reg [WIDTH-1:0] rail_q;

  // ==================================================================
  // storage; software must keep zeros in buck mode, not enforced here
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      rail_q <= {WIDTH{1'b0}};
    else if (wr_en_i)
      rail_q <= wr_bits_i;
  end

  assign rail_bits_o = rail_q;

endmodule

`default_nettype wire

// ---- bench/pmrc_top_sva.sv ----
// pmrc_top_sva.sv: port checks of the pad mode and rail bank
// assumes: bound to pmrc_top, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// checker
module pmrc_top_sva
(
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [3:0]  analog_mode_i,
  input wire logic [7:0]  direction_pull_select_o,
  input wire logic [19:0] pin_function_select_o,
  input wire logic [3:0]  pad_out_en_o,
  input wire logic [3:0]  pad_pull_up_o,
  input wire logic [3:0]  pad_pull_down_o,
  input wire logic [7:0]  port_zero_rail_bits_o,
  input wire logic [5:0]  port_one_rail_bits_o,
  input wire logic [9:0]  port_two_rail_bits_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  drive_en_map_a:
    assert property (pad_out_en_o[0] == (direction_pull_select_o[1:0] == 2'h3 && !analog_mode_i[0]))
      else $error("drive enable wrong");
  pull_up_map_a:
    assert property (pad_pull_up_o[3] == (direction_pull_select_o[7:6] == 2'h1 && !analog_mode_i[3]))
      else $error("pull-up wrong");
  dirpull_write_a:
    assert property (reg_wr_i && reg_addr_i == 32'h5000_3052 |=>
      direction_pull_select_o[1:0] == $past(reg_wdata_i[9:8])) else $error("dirpull not stored");
  func_write_a:
    assert property (reg_wr_i && reg_addr_i == 32'h5000_3058 |=>
      pin_function_select_o[19:15] == $past(reg_wdata_i[4:0])) else $error("func not stored");
  rail_zero_one_a:
    assert property (reg_wr_i && reg_addr_i == 32'h5000_3070 |=> {port_one_rail_bits_o,
      port_zero_rail_bits_o} == $past(reg_wdata_i[13:0])) else $error("rail 0/1 wrong");
  rail_two_write_a:
    assert property (reg_wr_i && reg_addr_i == 32'h5000_3072 |=>
      port_two_rail_bits_o == $past(reg_wdata_i[9:0])) else $error("rail 2 wrong");
  rail_two_hold_a:
    assert property (!(reg_wr_i && reg_addr_i == 32'h5000_3072) |=>
      $stable(port_two_rail_bits_o)) else $error("rail 2 moved");
  odd_read_zero_a:
    assert property (reg_rd_i && reg_addr_i[0] |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
  cover property (pad_out_en_o[0]);
  cover property (reg_rd_i && reg_addr_i == 32'h5000_3070);
  cover property (port_two_rail_bits_o == 10'h201);
endmodule
bind pmrc_top pmrc_top_sva u_sva (.*);
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top.sv: register-level test of the pad mode and rail bank
// assumes: pmrc_top with strobe port, 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i;
  logic [31:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic [3:0]  analog_mode_i;
  wire  [15:0] reg_rdata_o;
  wire  [7:0]  direction_pull_select_o, port_zero_rail_bits_o;
  wire  [19:0] pin_function_select_o;
  wire  [3:0]  pad_out_en_o, pad_pull_up_o, pad_pull_down_o;
  wire  [5:0]  port_one_rail_bits_o;
  wire  [9:0]  port_two_rail_bits_o;
  int          fail_count = 0;
  int          n_checks = 0;
  pmrc_top DUT (.*);
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // ==================================================================
  // bus tasks, entered just after a rising edge
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    // idle edge: a following write never re-raises the strobe in the same step
    @(posedge sys_clk_i);
  endtask
  // idle edge after the check keeps the next strobe on an edge
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
    @(posedge sys_clk_i);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==================================================================
  // sequence
  initial
  begin
    {reset_n_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, analog_mode_i} <= '0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) rd(32'h5000_3052 + 2 * i, 16'h0200);
    rd(32'h5000_3070, 16'h0000);
    rd(32'h5000_3072, 16'h0000);
    chk(pad_pull_down_o, 4'hf);
    for (int c = 0; c < 4; c++)
    begin
      wr(32'h5000_3052, 16'hfcf5 & ~16'h0300 | (c << 8));
      rd(32'h5000_3052, 16'h0015 | (c << 8));
      chk({pad_pull_up_o[0], pad_pull_down_o[0], pad_out_en_o[0]}, {c == 1, c == 2, c == 3});
    end
    analog_mode_i <= 4'h1;
    @(posedge sys_clk_i);
    chk({pad_out_en_o[0], direction_pull_select_o[1:0]}, 3'h3);
    analog_mode_i <= 4'h0;
    wr(32'h5000_3058, 16'h011f);
    rd(32'h5000_3058, 16'h011f);
    chk({direction_pull_select_o, pin_function_select_o}, 28'h6bf_8015);
    chk(pad_pull_up_o, 4'h8);
    // supply assumed in boost mode, so 1 V rail bits may be set
    wr(32'h5000_3070, 16'hffff);
    rd(32'h5000_3070, 16'h3fff);
    wr(32'h5000_3070, 16'h2d81);
    rd(32'h5000_3070, 16'h2d81);
    chk({port_one_rail_bits_o, port_zero_rail_bits_o}, 14'h2d81);
    wr(32'h5000_3072, 16'hffff);
    rd(32'h5000_3072, 16'h03ff);
    wr(32'h5000_3072, 16'h0201);
    wr(32'h5000_3060, 16'hffff);
    wr(32'h5000_3053, 16'hffff);
    rd(32'h5000_3053, 16'h0000);
    chk(port_two_rail_bits_o, 10'h201);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk({direction_pull_select_o, pin_function_select_o}, 28'haa0_0000);
    chk({port_two_rail_bits_o, port_one_rail_bits_o, port_zero_rail_bits_o}, 0);
    wrap_up;
  end
  initial
  begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
